// File: src/pdfu_consts.svh
// Constants for the packed decimal format unit: field positions, patterns and last step indices.
`ifndef PDFU_CONSTS_SVH
`define PDFU_CONSTS_SVH

// Digit field width and the largest legal digit.
`define PDFU_DIG_W        4
`define PDFU_DIG_MAX      4'h9
// Wide decimal format layout: 18 digits in bytes 0..8, sign in bit 7 of byte 9.
`define PDFU_NUM_DIGITS   18
`define PDFU_MAG_MSB      71
`define PDFU_SIGN_BIT     79
// Decimal indefinite pattern written on a masked invalid store.
`define PDFU_BCD_INDEF    80'hFFFF_C000_0000_0000_0000
// Magnitude limit of the wide decimal format, ten to the eighteenth.
`define PDFU_MAG_LIMIT    64'h0DE0_B6B3_A764_0000
// Extended format: exponent bias plus the explicit integer bit position.
`define PDFU_EXP_TOP      15'h403E
// Last step index of the digit-serial load and of the bit-serial store.
`define PDFU_LOAD_LAST    7'h11
`define PDFU_STORE_LAST   7'h3F

`endif

// File: src/pdfu_pkg.sv
// Types shared by the packed decimal format unit.
package pdfu_pkg;

    // Lane width of a 128-bit vector operand.
    typedef enum logic [1:0] {
        LANE_BYTE,
        LANE_WORD,
        LANE_DWORD,
        LANE_QWORD
    } lane_size_t;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_STORE
    } conv_state_t;

endpackage : pdfu_pkg

// File: src/bcd_digit_check.sv
// Per-digit legality check over a group of decimal digits.
`timescale 1ns/1ps
`default_nettype none
`include "pdfu_consts.svh"

module bcd_digit_check #(
    parameter int N = 18
) (
    // Digits, digit 0 in the low nibble.
    input  wire logic [4*N-1:0] i_digits,
    // One flag per digit above nine.
    output logic      [N-1:0]   o_bad
);

    // Each nibble is an unsigned digit legal only from zero to nine.
    // Four-bit digit range.
    for (genvar g = 0; g < N; g++) begin : g_dig
        assign o_bad[g] = (i_digits[4*g +: 4] > `PDFU_DIG_MAX);
    end

endmodule : bcd_digit_check
`default_nettype wire

// File: src/lane_slicer.sv
// Selects one lane of a 128-bit vector operand, zero-extended to 64 bits.
`timescale 1ns/1ps
`default_nettype none

module lane_slicer
    import pdfu_pkg::*;
(
    // Vector operand and lane selection.
    input  wire logic [127:0]   i_vec,
    input  wire lane_size_t     i_size,
    input  wire logic [3:0]     i_index,
    // Selected lane.
    output logic      [63:0]    o_lane
);

    logic [127:0] shifted;
    logic [6:0]   shamt;
    logic [63:0]  mask;

    // Index wraps to the lane count of the chosen width.
    always_comb begin
        unique case (i_size)
            LANE_BYTE:  begin shamt = {i_index, 3'h0};      mask = 64'h0000_0000_0000_00FF; end
            LANE_WORD:  begin shamt = {i_index[2:0], 4'h0}; mask = 64'h0000_0000_0000_FFFF; end
            LANE_DWORD: begin shamt = {i_index[1:0], 5'h00}; mask = 64'h0000_0000_FFFF_FFFF; end
            LANE_QWORD: begin shamt = {i_index[0], 6'h00};  mask = 64'hFFFF_FFFF_FFFF_FFFF; end
        endcase
        shifted = i_vec >> shamt;
        o_lane  = shifted[63:0] & mask;
    end

endmodule : lane_slicer
`default_nettype wire

// File: src/packed_decimal_format_unit.sv
// Decimal byte check, wide decimal load and store conversion, and vector lane selection.
`timescale 1ns/1ps
`default_nettype none
`include "pdfu_consts.svh"

module packed_decimal_format_unit
    import pdfu_pkg::*;
(
    // Clock and reset.
    input  wire logic           I_CLOCK,
    input  wire logic           I_RESET,
    // Decimal byte check.
    input  wire logic           I_BYTE_VALID,
    input  wire logic [7:0]     I_BYTE_DATA,
    input  wire logic           I_BYTE_PACKED,
    input  wire logic           I_BYTE_MULDIV,
    output logic                O_BYTE_VALID,
    output logic      [6:0]     O_BYTE_VALUE,
    output logic                O_BYTE_BAD,
    // Shared readiness of the conversion sequencer.
    output logic                O_READY,
    // Decimal load.
    input  wire logic           I_LOAD_VALID,
    input  wire logic [79:0]    I_LOAD_DATA,
    output logic                O_LOAD_DONE,
    output logic      [79:0]    O_LOAD_RESULT,
    output logic                O_LOAD_BAD,
    // Decimal store.
    input  wire logic           I_STORE_VALID,
    input  wire logic           I_STORE_SIGN,
    input  wire logic [63:0]    I_STORE_MAG,
    input  wire logic           I_STORE_INVALID,
    output logic                O_STORE_DONE,
    output logic      [79:0]    O_STORE_DATA,
    output logic                O_STORE_INDEF,
    // Vector lane selection.
    input  wire logic           I_LANE_VALID,
    input  wire logic [127:0]   I_LANE_VEC,
    input  wire lane_size_t     I_LANE_SIZE,
    input  wire logic [3:0]     I_LANE_INDEX,
    output logic                O_LANE_VALID,
    output logic      [63:0]    O_LANE_DATA
);

    // Byte path state.
    logic        byte_valid_q, byte_valid_d;
    logic [6:0]  byte_value_q, byte_value_d;
    logic        byte_bad_q,   byte_bad_d;
    logic [1:0]  byte_dig_bad;

    // Lane path state.
    logic        lane_valid_q, lane_valid_d;
    logic [63:0] lane_data_q,  lane_data_d;
    logic [63:0] lane_sel;

    // Conversion sequencer state.
    conv_state_t state_q, state_d;
    logic [6:0]  cnt_q,   cnt_d;
    logic [63:0] acc_q,   acc_d;
    logic [71:0] bcd_q,   bcd_d;
    logic        sign_q,  sign_d;
    logic        ldbad_q, ldbad_d;
    logic        ld_done_q, ld_done_d;
    logic [79:0] ld_res_q,  ld_res_d;
    logic        ld_bad_q,  ld_bad_d;
    logic        st_done_q, st_done_d;
    logic [79:0] st_data_q, st_data_d;
    logic        st_indef_q, st_indef_d;

    logic [17:0] load_dig_bad;
    logic [71:0] dd_adj;
    logic [63:0] acc_next;
    logic        load_go;
    logic        store_go;
    logic        store_indef;

    // Digit checks on the byte operand and on the incoming wide decimal magnitude.
    bcd_digit_check #(.N(2)) u_byte_check (
        .i_digits (I_BYTE_DATA),
        .o_bad    (byte_dig_bad)
    );

    bcd_digit_check #(.N(`PDFU_NUM_DIGITS)) u_load_check (
        .i_digits (I_LOAD_DATA[`PDFU_MAG_MSB:0]),
        .o_bad    (load_dig_bad)
    );

    lane_slicer u_lane (
        .i_vec   (I_LANE_VEC),
        .i_size  (I_LANE_SIZE),
        .i_index (I_LANE_INDEX),
        .o_lane  (lane_sel)
    );

    // Byte interpretation, one cycle from request to answer.
    always_comb begin
        byte_valid_d = I_BYTE_VALID;
        byte_value_d = byte_value_q;
        byte_bad_d   = byte_bad_q;
        if (I_BYTE_VALID) begin
            if (I_BYTE_PACKED) begin
                byte_value_d = 7'({I_BYTE_DATA[7:4], 3'h0}) + 7'({I_BYTE_DATA[7:4], 1'h0})
                             + 7'(I_BYTE_DATA[3:0]);
                byte_bad_d   = |byte_dig_bad;
            end else begin
                byte_value_d = 7'(I_BYTE_DATA[3:0]);
                byte_bad_d   = byte_dig_bad[0] || (I_BYTE_MULDIV && (I_BYTE_DATA[7:4] != 4'h0));
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            byte_valid_q <= 1'b0;
            byte_value_q <= 7'h00;
            byte_bad_q   <= 1'b0;
        end else begin
            byte_valid_q <= byte_valid_d;
            byte_value_q <= byte_value_d;
            byte_bad_q   <= byte_bad_d;
        end
    end

    // Lane selection, registered for one cycle.
    always_comb begin
        lane_valid_d = I_LANE_VALID;
        lane_data_d  = I_LANE_VALID ? lane_sel : lane_data_q;
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            lane_valid_q <= 1'b0;
            lane_data_q  <= 64'h0;
        end else begin
            lane_valid_q <= lane_valid_d;
            lane_data_q  <= lane_data_d;
        end
    end

    // Add-three adjust of each decimal digit before the next binary bit shifts in.
    for (genvar g = 0; g < `PDFU_NUM_DIGITS; g++) begin : g_adj
        assign dd_adj[4*g +: 4] = (bcd_q[4*g +: 4] > 4'h4) ? bcd_q[4*g +: 4] + 4'h3
                                                          : bcd_q[4*g +: 4];
    end

    // Multiply by ten and add the next digit, most significant digit first.
    assign acc_next    = (acc_q << 3) + (acc_q << 1) + 64'(bcd_q[71:68]);
    assign load_go     = I_LOAD_VALID && (state_q == ST_IDLE);
    assign store_go    = I_STORE_VALID && !I_LOAD_VALID && (state_q == ST_IDLE);
    assign store_indef = I_STORE_INVALID || (I_STORE_MAG >= `PDFU_MAG_LIMIT);

    // Normalises an exact integer into sign, biased exponent and explicit significand.
    function automatic logic [79:0] to_extended(input logic sign, input logic [63:0] mag);
        logic [6:0] lz;
        logic       found;
        lz    = 7'h00;
        found = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            if (!found && mag[i]) begin
                found = 1'b1;
                lz    = 7'(63 - i);
            end
        end
        if (!found) begin
            to_extended = {sign, 79'h0};
        end else begin
            to_extended = {sign, `PDFU_EXP_TOP - 15'(lz), mag << lz};
        end
    endfunction : to_extended

    // Sequencer: digit-serial load and bit-serial store.
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        acc_d      = acc_q;
        bcd_d      = bcd_q;
        sign_d     = sign_q;
        ldbad_d    = ldbad_q;
        ld_done_d  = 1'b0;
        ld_res_d   = ld_res_q;
        ld_bad_d   = ld_bad_q;
        st_done_d  = 1'b0;
        st_data_d  = st_data_q;
        st_indef_d = st_indef_q;
        unique case (state_q)
            ST_IDLE: begin
                if (load_go) begin
                    state_d = ST_LOAD;
                    cnt_d   = 7'h00;
                    acc_d   = 64'h0;
                    // Eighteen digits from bytes zero to eight.
                    bcd_d   = I_LOAD_DATA[`PDFU_MAG_MSB:0];
                    // Only the top sign byte bit counts.
                    sign_d  = I_LOAD_DATA[`PDFU_SIGN_BIT];
                    // Malformed digits reported with the result.
                    ldbad_d = |load_dig_bad;
                end else if (store_go) begin
                    if (store_indef) begin
                        st_data_d  = `PDFU_BCD_INDEF;
                        st_indef_d = 1'b1;
                        st_done_d  = 1'b1;
                    end else begin
                        state_d = ST_STORE;
                        cnt_d   = 7'h00;
                        acc_d   = I_STORE_MAG;
                        bcd_d   = 72'h0;
                        sign_d  = I_STORE_SIGN;
                    end
                end
            end
            ST_LOAD: begin
                acc_d = acc_next;
                bcd_d = {bcd_q[67:0], 4'h0};
                cnt_d = cnt_q + 7'h01;
                if (cnt_q == `PDFU_LOAD_LAST) begin
                    state_d   = ST_IDLE;
                    ld_done_d = 1'b1;
                    // Integer below two to the sixty, so conversion is exact.
                    ld_res_d  = to_extended(sign_q, acc_next);
                    ld_bad_d  = ldbad_q;
                end
            end
            ST_STORE: begin
                bcd_d = {dd_adj[70:0], acc_q[63]};
                acc_d = {acc_q[62:0], 1'b0};
                cnt_d = cnt_q + 7'h01;
                if (cnt_q == `PDFU_STORE_LAST) begin
                    state_d    = ST_IDLE;
                    st_done_d  = 1'b1;
                    st_indef_d = 1'b0;
                    // Sign-magnitude, clean sign byte, digit 0 lowest.
                    st_data_d  = {sign_q, 7'h00, dd_adj[70:0], acc_q[63]};
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 7'h00;
            acc_q      <= 64'h0;
            bcd_q      <= 72'h0;
            sign_q     <= 1'b0;
            ldbad_q    <= 1'b0;
            ld_done_q  <= 1'b0;
            ld_res_q   <= 80'h0;
            ld_bad_q   <= 1'b0;
            st_done_q  <= 1'b0;
            st_data_q  <= 80'h0;
            st_indef_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            acc_q      <= acc_d;
            bcd_q      <= bcd_d;
            sign_q     <= sign_d;
            ldbad_q    <= ldbad_d;
            ld_done_q  <= ld_done_d;
            ld_res_q   <= ld_res_d;
            ld_bad_q   <= ld_bad_d;
            st_done_q  <= st_done_d;
            st_data_q  <= st_data_d;
            st_indef_q <= st_indef_d;
        end
    end

    // Port drive.
    assign O_BYTE_VALID  = byte_valid_q;
    assign O_BYTE_VALUE  = byte_value_q;
    assign O_BYTE_BAD    = byte_bad_q;
    assign O_READY       = (state_q == ST_IDLE);
    assign O_LOAD_DONE   = ld_done_q;
    assign O_LOAD_RESULT = ld_res_q;
    assign O_LOAD_BAD    = ld_bad_q;
    assign O_STORE_DONE  = st_done_q;
    assign O_STORE_DATA  = st_data_q;
    assign O_STORE_INDEF = st_indef_q;
    assign O_LANE_VALID  = lane_valid_q;
    assign O_LANE_DATA   = lane_data_q;

    // Digit check over a finished store, read only by the checks below.
    logic [17:0] st_out_bad;
    bcd_digit_check #(.N(`PDFU_NUM_DIGITS)) u_store_check (
        .i_digits (st_data_q[`PDFU_MAG_MSB:0]),
        .o_bad    (st_out_bad)
    );

    // Checks on the datapath.
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);

    a_store_digits_legal: assert property (O_STORE_DONE && !O_STORE_INDEF |-> st_out_bad == 18'h0)
        else $error("store produced a digit above nine");
    a_byte_unpacked_val: assert property (I_BYTE_VALID && !I_BYTE_PACKED
        |=> O_BYTE_VALID && O_BYTE_VALUE == 7'($past(I_BYTE_DATA[3:0])))
        else $error("unpacked byte value not the low nibble");
    a_byte_muldiv_high: assert property (I_BYTE_VALID && !I_BYTE_PACKED && I_BYTE_MULDIV
        && I_BYTE_DATA[7:4] != 4'h0 |=> O_BYTE_BAD)
        else $error("nonzero high nibble not flagged for multiply or divide");
    a_byte_packed_val: assert property (I_BYTE_VALID && I_BYTE_PACKED && !byte_dig_bad[1]
        && !byte_dig_bad[0] |=> O_BYTE_VALUE == 7'($past(I_BYTE_DATA[7:4])) * 7'h0A
        + 7'($past(I_BYTE_DATA[3:0])))
        else $error("packed byte weighting wrong");
    a_load_latency: assert property (load_go |=> !O_READY [*8] ##11 O_LOAD_DONE)
        else $error("load did not finish on time");
    a_store_low_digit: assert property (store_go && !store_indef && I_STORE_MAG == 64'h1
        |-> ##65 O_STORE_DONE && O_STORE_DATA[71:0] == 72'h1)
        else $error("least digit not in low nibble of byte zero");
    a_load_sign_kept: assert property (load_go |-> ##19
        O_LOAD_RESULT[79] == $past(I_LOAD_DATA[79], 19))
        else $error("load sign not taken from the top bit");
    a_store_sign_mag: assert property (store_go && !store_indef |-> ##65 O_STORE_DONE
        && O_STORE_DATA[79] == $past(I_STORE_SIGN, 65) && O_STORE_DATA[78:72] == 7'h00)
        else $error("store sign byte not sign-magnitude");
    a_load_zero_sign: assert property (load_go && I_LOAD_DATA[71:0] == 72'h0
        |-> ##19 O_LOAD_RESULT[78:0] == 79'h0)
        else $error("zero magnitude did not load as signed zero");
    a_load_normal: assert property (O_LOAD_DONE && O_LOAD_RESULT[78:64] != 15'h0
        |-> O_LOAD_RESULT[63])
        else $error("loaded value not normalised");
    a_store_indef: assert property (store_go && I_STORE_INVALID
        |=> O_STORE_DONE && O_STORE_INDEF && O_STORE_DATA == `PDFU_BCD_INDEF)
        else $error("masked invalid store did not write indefinite");
    a_lane_qword_high: assert property (I_LANE_VALID && I_LANE_SIZE == LANE_QWORD
        && I_LANE_INDEX[0] |=> O_LANE_DATA == $past(I_LANE_VEC[127:64]))
        else $error("upper quadword lane wrong");
    a_load_bad_flag: assert property (load_go && load_dig_bad != 18'h0
        |-> ##19 O_LOAD_DONE && O_LOAD_BAD)
        else $error("malformed load digit not flagged");

    c_load_done: cover property (load_go ##19 O_LOAD_DONE);
    c_store_conv: cover property (store_go && !store_indef ##65 O_STORE_DONE);
    c_store_indef: cover property (store_go && I_STORE_INVALID ##1 O_STORE_INDEF);
    c_byte_bad: cover property (I_BYTE_VALID && I_BYTE_PACKED ##1 O_BYTE_BAD);

endmodule : packed_decimal_format_unit
`default_nettype wire

// File: tb/pipeline_model.sv
// Execution pipeline model that issues decimal load and store requests.
`timescale 1ns/1ps
`default_nettype none

module pipeline_model (
    // Clock and sequencer status.
    input  wire logic        i_clock,
    input  wire logic        i_ready,
    input  wire logic        i_load_done,
    input  wire logic        i_store_done,
    // Load request.
    output logic             o_load_valid,
    output logic      [79:0] o_load_data,
    // Store request.
    output logic             o_store_valid,
    output logic             o_store_sign,
    output logic      [63:0] o_store_mag,
    output logic             o_store_invalid
);
    // Idle request lines at time zero.
    initial begin
        o_load_valid = 1'b0;
        o_load_data = 80'h0;
        o_store_valid = 1'b0;
        o_store_sign = 1'b0;
        o_store_mag = 64'h0;
        o_store_invalid = 1'b0;
    end

    // Holds the request until an edge sees the sequencer idle, then passes that edge.
    task automatic wait_taken();
        int n;
        n = 0;
        while (!i_ready && n < 200) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        @(posedge i_clock);
        #1;
    endtask : wait_taken

    // Counts cycles from the taking edge until the done pulse is seen.
    task automatic wait_done(input logic store, output int lat);
        lat = 1;
        while (!(store ? i_store_done : i_load_done) && lat < 200) begin
            @(posedge i_clock);
            #1;
            lat++;
        end
    endtask : wait_done

    task automatic do_load(input logic [79:0] d, output int lat);
        // One edge passes first so a request never drops and rises in one step.
        @(posedge i_clock);
        #1;
        o_load_valid = 1'b1;
        o_load_data = d;
        wait_taken();
        o_load_valid = 1'b0;
        o_load_data = ~d;
        wait_done(1'b0, lat);
    endtask : do_load

    // Store request; released lines show inverted values so stale data cannot pass.
    task automatic do_store(input logic s, input logic [63:0] m, input logic inv, output int lat);
        @(posedge i_clock);
        #1;
        o_store_valid = 1'b1;
        o_store_sign = s;
        o_store_mag = m;
        o_store_invalid = inv;
        wait_taken();
        o_store_valid = 1'b0;
        o_store_sign = ~s;
        o_store_mag = ~m;
        o_store_invalid = ~inv;
        wait_done(1'b1, lat);
    endtask : do_store
endmodule : pipeline_model
`default_nettype wire

// File: tb/packed_decimal_format_unit_tb.sv
// Self-checking bench for the packed decimal format unit.
`timescale 1ns/1ps
`default_nettype none

module packed_decimal_format_unit_tb import pdfu_pkg::*;;
    // One row: byte and lane requests beside the outputs they should give.
    typedef struct packed {
        logic [7:0]  data;
        logic        pk;
        logic        md;
        logic [6:0]  value;
        logic        bad;
        lane_size_t  size;
        logic [3:0]  index;
        logic [63:0] lane;
    } row_t;

    logic I_CLOCK, I_RESET, I_BYTE_VALID, I_BYTE_PACKED, I_BYTE_MULDIV, I_LANE_VALID;
    logic [7:0] I_BYTE_DATA;
    logic [127:0] I_LANE_VEC;
    lane_size_t I_LANE_SIZE;
    logic [3:0] I_LANE_INDEX;
    logic O_BYTE_VALID, O_BYTE_BAD, O_READY, O_LOAD_DONE, O_LOAD_BAD, O_STORE_DONE;
    logic O_STORE_INDEF, O_LANE_VALID, I_LOAD_VALID, I_STORE_VALID, I_STORE_SIGN;
    logic I_STORE_INVALID;
    logic [6:0] O_BYTE_VALUE;
    logic [79:0] O_LOAD_RESULT, O_STORE_DATA, I_LOAD_DATA;
    logic [63:0] O_LANE_DATA, I_STORE_MAG;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;

    // high nibble rows; digits above nine; lane wrap.
    row_t rows [10] = '{
        '{8'h47, 1'b1, 1'b0, 7'h2F, 1'b0, LANE_BYTE, 4'h0, 64'h00},
        '{8'h99, 1'b1, 1'b0, 7'h63, 1'b0, LANE_BYTE, 4'hF, 64'h0F},
        '{8'h00, 1'b1, 1'b1, 7'h00, 1'b0, LANE_WORD, 4'h7, 64'h0F0E},
        '{8'hA3, 1'b1, 1'b0, 7'h67, 1'b1, LANE_WORD, 4'h9, 64'h0302},
        '{8'h3C, 1'b1, 1'b0, 7'h2A, 1'b1, LANE_DWORD, 4'h3, 64'h0F0E0D0C},
        '{8'hF5, 1'b0, 1'b0, 7'h05, 1'b0, LANE_DWORD, 4'h6, 64'h0B0A0908},
        '{8'hF5, 1'b0, 1'b1, 7'h05, 1'b1, LANE_QWORD, 4'h0, 64'h0706050403020100},
        '{8'h05, 1'b0, 1'b1, 7'h05, 1'b0, LANE_QWORD, 4'h1, 64'h0F0E0D0C0B0A0908},
        '{8'h0B, 1'b0, 1'b0, 7'h0B, 1'b1, LANE_BYTE, 4'h5, 64'h05},
        '{8'h09, 1'b0, 1'b1, 7'h09, 1'b0, LANE_WORD, 4'h0, 64'h0100}
    };

    packed_decimal_format_unit i_packed_decimal_format_unit (
        .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_BYTE_VALID(I_BYTE_VALID),
        .I_BYTE_DATA(I_BYTE_DATA), .I_BYTE_PACKED(I_BYTE_PACKED), .I_BYTE_MULDIV(I_BYTE_MULDIV),
        .O_BYTE_VALID(O_BYTE_VALID), .O_BYTE_VALUE(O_BYTE_VALUE), .O_BYTE_BAD(O_BYTE_BAD),
        .O_READY(O_READY), .I_LOAD_VALID(I_LOAD_VALID), .I_LOAD_DATA(I_LOAD_DATA),
        .O_LOAD_DONE(O_LOAD_DONE), .O_LOAD_RESULT(O_LOAD_RESULT), .O_LOAD_BAD(O_LOAD_BAD),
        .I_STORE_VALID(I_STORE_VALID), .I_STORE_SIGN(I_STORE_SIGN), .I_STORE_MAG(I_STORE_MAG),
        .I_STORE_INVALID(I_STORE_INVALID), .O_STORE_DONE(O_STORE_DONE),
        .O_STORE_DATA(O_STORE_DATA), .O_STORE_INDEF(O_STORE_INDEF), .I_LANE_VALID(I_LANE_VALID),
        .I_LANE_VEC(I_LANE_VEC), .I_LANE_SIZE(I_LANE_SIZE), .I_LANE_INDEX(I_LANE_INDEX),
        .O_LANE_VALID(O_LANE_VALID), .O_LANE_DATA(O_LANE_DATA)
    );

    pipeline_model i_pipeline_model (
        .i_clock(I_CLOCK), .i_ready(O_READY), .i_load_done(O_LOAD_DONE),
        .i_store_done(O_STORE_DONE), .o_load_valid(I_LOAD_VALID), .o_load_data(I_LOAD_DATA),
        .o_store_valid(I_STORE_VALID), .o_store_sign(I_STORE_SIGN),
        .o_store_mag(I_STORE_MAG), .o_store_invalid(I_STORE_INVALID)
    );

    // Core clock at 25 MHz.
    initial begin
        I_CLOCK = 1'b0;
        forever #20 I_CLOCK = ~I_CLOCK;
    end

    // Cuts a hang short.
    always @(posedge I_CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check(input string name, input logic [79:0] exp, input logic [79:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // Expected extended format of a wide decimal value.
    function automatic logic [79:0] ext_of(input logic [79:0] d);
        logic [63:0] m;
        logic [14:0] e;
        m = 64'h0;
        for (int k = 17; k >= 0; k--)
            m = m * 10 + 64'(d[k*4 +: 4]);
        if (m == 64'h0)
            return {d[79], 79'h0};
        e = 15'h403E;
        while (!m[63]) begin
            m = m << 1;
            e = e - 15'h1;
        end
        return {d[79], e, m};
    endfunction : ext_of

    // Expected wide decimal image of a store.
    function automatic logic [79:0] dec_of(input logic s, input logic [63:0] m, input logic inv);
        logic [79:0] r;
        if (inv || m >= 64'h0DE0_B6B3_A764_0000)
            return 80'hFFFF_C000_0000_0000_0000;
        r = {s, 79'h0};
        for (int k = 0; k < 18; k++) begin
            r[k*4 +: 4] = 4'(m % 10);
            m = m / 10;
        end
        return r;
    endfunction : dec_of

    task automatic run_load(input logic [79:0] d, input logic bad);
        int lat;
        i_pipeline_model.do_load(d, lat);
        check("load latency", 80'h13, 80'(lat));
        check("load bad", {79'h0, bad}, {79'h0, O_LOAD_BAD});
        if (!bad) check("load result", ext_of(d), O_LOAD_RESULT);
    endtask : run_load

    task automatic run_store(input logic s, input logic [63:0] m, input logic inv);
        int lat;
        logic [79:0] e;
        e = dec_of(s, m, inv);
        i_pipeline_model.do_store(s, m, inv, lat);
        check("store latency", (e[79:64] == 16'hFFFF) ? 80'h1 : 80'h41, 80'(lat));
        check("store data", e, O_STORE_DATA);
        check("store indef", {79'h0, e[79:64] == 16'hFFFF}, {79'h0, O_STORE_INDEF});
    endtask : run_store

    // Main sequence: reset, row loop, then load and store cases.
    initial begin
        {I_RESET, I_BYTE_VALID, I_BYTE_PACKED, I_BYTE_MULDIV, I_LANE_VALID} = 5'h10;
        I_BYTE_DATA = 8'h0;
        I_LANE_VEC = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
        I_LANE_SIZE = LANE_BYTE;
        I_LANE_INDEX = 4'h0;
        repeat (20) @(posedge I_CLOCK);
        #1;
        I_RESET = 1'b0;
        check("reset ready", 80'h1, {79'h0, O_READY});
        check("reset data", 80'h0, O_STORE_DATA | O_LOAD_RESULT);
        for (int i = 0; i <= 10; i++) begin
            @(posedge I_CLOCK);
            #1;
            if (i > 0) begin
                check("byte valid", 80'h1, {79'h0, O_BYTE_VALID});
                check("byte value", 80'(rows[i-1].value), 80'(O_BYTE_VALUE));
                check("byte bad", 80'(rows[i-1].bad), 80'(O_BYTE_BAD));
                check("lane valid", 80'h1, {79'h0, O_LANE_VALID});
                check("lane data", 80'(rows[i-1].lane), 80'(O_LANE_DATA));
            end
            I_BYTE_VALID = (i < 10);
            I_LANE_VALID = (i < 10);
            if (i < 10) begin
                {I_BYTE_DATA, I_BYTE_PACKED, I_BYTE_MULDIV} = {rows[i].data, rows[i].pk, rows[i].md};
                {I_LANE_SIZE, I_LANE_INDEX} = {rows[i].size, rows[i].index};
            end
        end
        run_load(80'h0, 1'b0);
        run_load(80'h8000_0000_0000_0000_0000, 1'b0);
        run_load(80'h7F00_0000_0000_0000_0001, 1'b0);
        run_load(80'h0099_9999_9999_9999_9999, 1'b0);
        run_load(80'h8012_3456_7890_1234_5678, 1'b0);
        run_load(80'h0000_0000_0000_0000_00A0, 1'b1);
        run_store(1'b1, 64'h1, 1'b0);
        run_store(1'b0, 64'h0DE0_B6B3_A763_FFFF, 1'b0);
        run_store(1'b0, 64'h0DE0_B6B3_A764_0000, 1'b0);
        run_store(1'b1, 64'h5, 1'b1);
        run_store(1'b0, 64'h0, 1'b1);
        run_store(1'b1, 64'h0, 1'b0);
        run_store(1'b1, 64'h075B_CD15, 1'b0);
        tally_and_finish();
    end
endmodule : packed_decimal_format_unit_tb
`default_nettype wire
